/* File: verilog/mck_consts.svh */
// constants for the machine-check response block: offsets, bits, resets
// assumes inclusion by bare name from the package and the design modules
//
// Overview of operation
// - storage loop setting forces check near reset end
// - storage loop compare match starts system reset
// - mask bit zero suppresses hardware check interrupts
// - disable switch position suppresses hardware check interrupts
// - console forced check is never maskable
// - stop position gives hardstop, interrupt only for forced check
// - suppressed checks stay pending until cleared
// - reset, button, interrupt clear all check latches
// - allowed check raises interrupt and cycle requests
// - allowed sequence check stops compute clock
// - allowed error forces end execute, write phase four
// - no forced end during status load or interrupt
// - halted clocks raise end execute, then interrupt latch
// - interrupt latch holds until its cycles finish
// - check during interrupt cycles sets hardstop
// - clear checks at read phase two, sample four
// - master error hardstop in load, regen or stop
// - error during storage validation sets hardstop
// - reset start or start latch clears hardstop
// - no console indicator for forced check latch
// - duplicate sequence latches set sequence check
// - forced restart sets forced check after reset
`ifndef MCK_CONSTS_SVH
`define MCK_CONSTS_SVH
// ------------------------------------------------------------
// register port
// ------------------------------------------------------------
`define MCK_ADDR_W 4
`define MCK_REG_STATUS 4'h0
`define MCK_REG_CONTROL 4'h4
`define MCK_CTRL_CHK_RESET 0
`define MCK_CTRL_LOOP_EN 1
`define MCK_CTRL_RESET 32'h0000_0002
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MCK_MASK_BIT 13
`define MCK_CHK_PARITY 0
`define MCK_CHK_CYCLE 1
`define MCK_CHK_SEQ 2
`define MCK_CHK_FORCED 3
`define MCK_ST_HARDSTOP 3
`define MCK_ST_INTLATCH 4
`define MCK_ST_DBLSAMPLE 5
`define MCK_CHK_RESET_VAL 4'h0
`endif

/* File: verilog/mck_pkg.sv */
// types shared by the machine-check response modules
// assumes the constants header sits in the include path
`include "mck_consts.svh"
package mck_pkg;
   // switch select: normal, disable, stop, forced restart
   typedef enum logic [1:0] {CHK_NORMAL, CHK_DISABLE, CHK_STOP, CHK_FORCED} chk_sel_t;
   // interrupt sequencing
   typedef enum logic [1:0] {S_IDLE, S_WAIT_HALT, S_END_EXEC, S_INT} mck_state_t;
   // true when more than one bit of a group is set
   function automatic logic more_than_one(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         n = n + {3'h0, v[i]};
      end
      return n > 4'h1;
   endfunction
endpackage

/* File: verilog/mck_if.sv */
// carrier between the top of the machine-check block and its latch modules
// assumes one clock domain, the system clock
`timescale 1ns/100ps
interface mck_if;
   logic [3:0] chk_set;
   logic chk_clr;
   logic [3:0] chk_q;
   logic hs_set;
   logic hs_clr;
   logic hs_q;
   logic dbl_set;
   logic dbl_clr;
   logic dbl_q;
   modport ctl (output chk_set, chk_clr, hs_set, hs_clr, dbl_set, dbl_clr, input chk_q, hs_q, dbl_q);
   modport chk (input chk_set, chk_clr, output chk_q);
   modport hst (input hs_set, hs_clr, dbl_set, dbl_clr, output hs_q, dbl_q);
endinterface

/* File: verilog/check_latches.sv */
// cpu check latches: parity, cycle control, sequence control, console forced
// assumes set and clear terms come from the top, synchronous reset high
`timescale 1ns/100ps
`include "mck_consts.svh"
module check_latches
   import mck_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   mck_if.chk bus
);
   logic [3:0] chk_q;
   logic [3:0] chk_d;

   // a set in the clearing cycle wins so no error is lost
   assign chk_d = bus.chk_set | (bus.chk_clr ? `MCK_CHK_RESET_VAL : chk_q);

   // ------------------------------------------------------------
   // latch storage
   // ------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         chk_q <= `MCK_CHK_RESET_VAL;
      else
         chk_q <= chk_d;
   end

   assign bus.chk_q = chk_q;
endmodule

/* File: verilog/hardstop_ctl.sv */
// hardstop latch and double-error sample latch
// assumes set and clear terms come from the top, synchronous reset high
`timescale 1ns/100ps
module hardstop_ctl
   import mck_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   mck_if.hst bus
);
   logic hs_q;
   logic hs_d;
   logic dbl_q;
   logic dbl_d;

   // set beats clear: a stop reason in the start cycle still stops
   assign hs_d = bus.hs_set | (hs_q & ~bus.hs_clr);
   assign dbl_d = bus.dbl_set | (dbl_q & ~bus.dbl_clr);

   // ------------------------------------------------------------
   // latch storage
   // ------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         hs_q <= 1'b0;
         dbl_q <= 1'b0;
      end
      else
      begin
         hs_q <= hs_d;
         dbl_q <= dbl_d;
      end
   end

   assign bus.hs_q = hs_q;
   assign bus.dbl_q = dbl_q;
endmodule

/* File: verilog/machine_check_response.sv */
// machine-check response: decides ignore, interrupt or hardstop
// assumes phase strobes are one-cycle pulses synchronous to the system clock
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "mck_consts.svh"
module machine_check_response
   import mck_pkg::*;
#(
   parameter int STATUS_W = 32
)
(
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   input wire logic i_CC1,
   input wire logic i_CC2,
   input wire logic i_WC4,
   input wire logic i_RC2,
   input wire logic i_RC4,
   input wire logic i_CP2,
   input wire logic [STATUS_W-1:0] i_STATUS_WORD_FIRST_HALF,
   input wire logic [1:0] i_CHECK_SEL,
   input wire logic i_STORAGE_COMPARE_LOOP_SETTING,
   input wire logic i_ADDR_COMPARE_MATCH,
   input wire logic i_TIMER_PULSE,
   input wire logic i_CHECK_RESET_BUTTON,
   input wire logic i_SYSRST_START,
   input wire logic i_SYSRST_LATCH3,
   input wire logic i_START_LATCH,
   input wire logic i_PARITY_CHECK_SET,
   input wire logic i_CYCLE_CHECK_SET,
   input wire logic [4:0] i_SEQ_FIXED,
   input wire logic [3:0] i_SEQ_FLOAT,
   input wire logic i_MACHINE_ERROR,
   input wire logic i_LOAD_STATUS_OP,
   input wire logic i_INT_CYCLE,
   input wire logic i_CLOCKS_HALTED,
   input wire logic i_INT_CYCLES_DONE,
   input wire logic i_INITIAL_PROGRAM_LOAD,
   input wire logic i_REGEN_STORAGE,
   input wire logic i_EXT_VALIDATE,
   input wire logic [`MCK_ADDR_W-1:0] i_ADDR,
   input wire logic [31:0] i_WDATA,
   input wire logic i_WR,
   input wire logic i_RD,
   output logic [31:0] o_RDATA,
   output logic o_MCK_INT_REQ,
   output logic o_INT_CYCLE_REQ,
   output logic o_INHIBIT_COMPUTE_CLOCK,
   output logic o_FORCE_END_EXECUTE,
   output logic o_MCK_END_EXECUTE,
   output logic o_MCK_INT_LATCH,
   output logic o_RESET_CPU_ERR,
   output logic o_SYS_RESET_REQ,
   output logic o_HARDSTOP,
   output logic o_ANY_CPU_ERROR
);
   mck_if lat ();

   // ------------------------------------------------------------
   // sub-blocks
   // ------------------------------------------------------------
   check_latches u_chk
   (
      .i_clk(I_CLK_SYS),
      .i_rst(I_SYS_RST),
      .bus(lat.chk)
   );

   hardstop_ctl u_hst
   (
      .i_clk(I_CLK_SYS),
      .i_rst(I_SYS_RST),
      .bus(lat.hst)
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   mck_state_t state_q;
   mck_state_t state_d;
   logic forced_restart_q;
   logic forced_restart_d;
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // ------------------------------------------------------------
   // switch decode
   // ------------------------------------------------------------
   wire chk_sel_t sel = chk_sel_t'(i_CHECK_SEL);
   wire sel_disable = (sel == CHK_DISABLE);
   wire sel_stop = (sel == CHK_STOP);
   wire sel_forced = (sel == CHK_FORCED);
   wire mask_bit = i_STATUS_WORD_FIRST_HALF[`MCK_MASK_BIT];
   wire compute_ph = i_CC1 | i_CC2;
   wire loop_on = i_STORAGE_COMPARE_LOOP_SETTING & ctrl_q[`MCK_CTRL_LOOP_EN];

   // ------------------------------------------------------------
   // check latch set and clear terms
   // ------------------------------------------------------------
   wire seq_err = more_than_one({3'h0, i_SEQ_FIXED}) | more_than_one({4'h0, i_SEQ_FLOAT});
   wire set_seq = seq_err & compute_ph;
   // loop setting forces a check as the system reset draws to a close
   wire set_forced_loop = loop_on & i_SYSRST_LATCH3 & compute_ph;
   // forced restart: the reset started by the timer ends the same way
   wire set_forced_rst = forced_restart_q & i_SYSRST_LATCH3 & compute_ph;
   wire set_forced = set_forced_loop | set_forced_rst;
   wire wr_hit = i_WR & (i_ADDR == `MCK_REG_CONTROL);
   wire sw_chk_reset = wr_hit & i_WDATA[`MCK_CTRL_CHK_RESET];
   // interrupt-cycle clear lands at read phase two, before the sample
   wire reset_cpu_err = (state_q == S_INT) & i_RC2;
   // clear at the start of reset so the forced set near its end survives
   wire master_reset = i_SYSRST_START | i_CHECK_RESET_BUTTON | sw_chk_reset | reset_cpu_err;

   assign lat.chk_set = {set_forced, set_seq, i_CYCLE_CHECK_SET, i_PARITY_CHECK_SET};
   assign lat.chk_clr = master_reset;

   // ------------------------------------------------------------
   // interrupt enabling
   // ------------------------------------------------------------
   wire console_forced = lat.chk_q[`MCK_CHK_FORCED];
   wire any_cpu_err = |lat.chk_q; // pending until cleared
   // mask and switch each suppress; stop interrupts only on a console forced check
   wire hw_allow = mask_bit & ~sel_disable & ~sel_stop;
   wire allow = hw_allow | console_forced;
   wire int_req = allow & any_cpu_err;
   // a forced end mid status store would leave half a status word
   wire end_blocked = i_LOAD_STATUS_OP | i_INT_CYCLE;
   wire master_err = any_cpu_err | i_MACHINE_ERROR;

   // ------------------------------------------------------------
   // hardstop set and clear terms
   // ------------------------------------------------------------
   wire hs_double = lat.dbl_q & any_cpu_err;
   wire hs_load = master_err & (i_INITIAL_PROGRAM_LOAD | i_REGEN_STORAGE) & ~sel_disable;
   wire hs_stop = master_err & sel_stop;
   wire hs_valid = master_err & i_EXT_VALIDATE & ~sel_disable;

   assign lat.hs_set = hs_double | hs_load | hs_stop | hs_valid;
   assign lat.hs_clr = i_SYSRST_START | i_START_LATCH;
   // sample opens at read phase four of the interrupt cycles
   assign lat.dbl_set = (state_q == S_INT) & i_RC4 & ~i_INT_CYCLES_DONE;
   assign lat.dbl_clr = i_INT_CYCLES_DONE | i_SYSRST_START;

   // ------------------------------------------------------------
   // interrupt sequencing
   // ------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         S_IDLE:
            if (int_req & ~end_blocked)
               state_d = S_WAIT_HALT;
         S_WAIT_HALT:
            if (~int_req)
               state_d = S_IDLE;
            else if (i_CLOCKS_HALTED)
               state_d = S_END_EXEC;
         S_END_EXEC:
            if (i_CP2)
               state_d = S_INT; // first clock pulse two sets the latch
         S_INT:
            if (i_INT_CYCLES_DONE)
               state_d = S_IDLE;
         default:
            state_d = S_IDLE;
      endcase
   end

   // forced-restart latch: armed by the timer, spent at reset end
   assign forced_restart_d = (i_TIMER_PULSE & sel_forced) | (forced_restart_q & ~set_forced_rst);

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   wire rd_status = i_RD & (i_ADDR == `MCK_REG_STATUS);
   wire rd_control = i_RD & (i_ADDR == `MCK_REG_CONTROL);
   // forced latch deliberately left out of the readout
   wire [31:0] status_word = {26'h0, lat.dbl_q, (state_q == S_INT), lat.hs_q,
                              lat.chk_q[`MCK_CHK_SEQ:`MCK_CHK_PARITY]};

   always_comb
   begin
      if (rd_status)
         rdata_d = status_word;
      else if (rd_control)
         rdata_d = ctrl_q;
      else
         rdata_d = 32'h0000_0000;
   end

   // check-reset bit acts on the write and is never stored
   assign ctrl_d = wr_hit ? (i_WDATA & `MCK_CTRL_RESET) : ctrl_q;

   // ------------------------------------------------------------
   // flip-flops
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
      begin
         state_q <= S_IDLE;
         forced_restart_q <= 1'b0;
         ctrl_q <= `MCK_CTRL_RESET;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         state_q <= state_d;
         forced_restart_q <= forced_restart_d;
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_RDATA = rdata_q;
   assign o_MCK_INT_REQ = int_req;
   assign o_INT_CYCLE_REQ = int_req;
   assign o_INHIBIT_COMPUTE_CLOCK = allow & lat.chk_q[`MCK_CHK_SEQ];
   assign o_FORCE_END_EXECUTE = int_req & i_WC4 & ~end_blocked;
   assign o_MCK_END_EXECUTE = (state_q == S_END_EXEC);
   assign o_MCK_INT_LATCH = (state_q == S_INT);
   assign o_RESET_CPU_ERR = reset_cpu_err;
   // storage loop: every compare hit restarts; forced restart on the timer
   assign o_SYS_RESET_REQ = (loop_on & i_ADDR_COMPARE_MATCH) | (i_TIMER_PULSE & sel_forced);
   assign o_HARDSTOP = lat.hs_q;
   assign o_ANY_CPU_ERROR = any_cpu_err;
endmodule

/* File: test/mck_sequencer_model.sv */
// sequencer model: halts the clocks after a check request, runs the clock pulse phase
// assumes the block's request and end execute outputs, one system clock
`timescale 1ns/100ps
module mck_sequencer_model
#(
   parameter int HALT_DLY = 3
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic i_end_exec,
   output logic o_halted,
   output logic o_cp2
);
   // ------------------------------------------------------------
   // clock control
   // ------------------------------------------------------------
   logic [3:0] cnt_q;
   logic [1:0] ph_q;
   // the clocks stop only once the current step drains, hence the delay
   always_ff @(posedge i_clk)
   begin
      if (i_rst || !(i_req || i_end_exec))
         cnt_q <= 4'h0;
      else if (cnt_q < 4'(HALT_DLY))
         cnt_q <= cnt_q + 4'h1;
   end
   // phase 2 pulse once every four cycles, free running like the real clock ring
   always_ff @(posedge i_clk)
   begin
      ph_q <= i_rst ? 2'h0 : ph_q + 2'h1;
   end
   // halted falls as soon as both the request and end execute go away
   assign o_halted = (cnt_q == 4'(HALT_DLY)) && (i_req || i_end_exec);
   assign o_cp2 = (ph_q == 2'h3);
endmodule

/* File: test/machine_check_response_properties.sv */
// checker for the machine-check response block, bound onto its top module
// assumes one system clock and a synchronous active-high reset
`timescale 1ns/100ps
module machine_check_response_properties
(
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   input wire logic i_CC1,
   input wire logic i_CC2,
   input wire logic i_WC4,
   input wire logic i_CP2,
   input wire logic [1:0] i_CHECK_SEL,
   input wire logic i_SYSRST_START,
   input wire logic i_START_LATCH,
   input wire logic i_PARITY_CHECK_SET,
   input wire logic i_CYCLE_CHECK_SET,
   input wire logic i_MACHINE_ERROR,
   input wire logic i_LOAD_STATUS_OP,
   input wire logic i_INT_CYCLE,
   input wire logic i_INT_CYCLES_DONE,
   input wire logic o_MCK_INT_REQ,
   input wire logic o_INT_CYCLE_REQ,
   input wire logic o_INHIBIT_COMPUTE_CLOCK,
   input wire logic o_FORCE_END_EXECUTE,
   input wire logic o_MCK_END_EXECUTE,
   input wire logic o_MCK_INT_LATCH,
   input wire logic o_RESET_CPU_ERR,
   input wire logic o_HARDSTOP,
   input wire logic o_ANY_CPU_ERROR
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);
   // a request needs a latched check, and always brings the cycle request
   req_cause_a: assert property (o_MCK_INT_REQ |-> o_ANY_CPU_ERROR && o_INT_CYCLE_REQ)
      else $error("interrupt request without check or cycle request");
   clock_inhibit_a: assert property (o_INHIBIT_COMPUTE_CLOCK |-> o_MCK_INT_REQ)
      else $error("compute clock inhibited without allowed check");
   force_end_a: assert property (o_FORCE_END_EXECUTE |-> i_WC4 && o_MCK_INT_REQ && !i_LOAD_STATUS_OP && !i_INT_CYCLE)
      else $error("forced end execute at the wrong time");
   int_set_a: assert property ($rose(o_MCK_INT_LATCH) |-> $past(o_MCK_END_EXECUTE) && $past(i_CP2))
      else $error("interrupt latch set without end execute and phase 2");
   int_hold_a: assert property (o_MCK_INT_LATCH && !i_INT_CYCLES_DONE && !i_SYSRST_START |=> o_MCK_INT_LATCH)
      else $error("interrupt latch dropped early");
   // no new set term may race the clear, or the latch could legally stay up
   err_clear_a: assert property (o_RESET_CPU_ERR && !i_PARITY_CHECK_SET && !i_CYCLE_CHECK_SET && !i_CC1 && !i_CC2
      |=> !o_ANY_CPU_ERROR)
      else $error("check latches not cleared by interrupt clear");
   stop_hs_a: assert property (i_CHECK_SEL == 2'h2 && i_MACHINE_ERROR |=> o_HARDSTOP)
      else $error("machine error at stop position without hardstop");
   hs_clear_a: assert property ((i_SYSRST_START || i_START_LATCH) && !i_MACHINE_ERROR && !o_ANY_CPU_ERROR
      |=> !o_HARDSTOP)
      else $error("hardstop not cleared");
   cover property ($rose(o_MCK_INT_LATCH));
   cover property (o_FORCE_END_EXECUTE);
   cover property ($rose(o_HARDSTOP));
endmodule
bind machine_check_response machine_check_response_properties u_props (.I_CLK_SYS, .I_SYS_RST, .i_CC1, .i_CC2,
   .i_WC4, .i_CP2, .i_CHECK_SEL, .i_SYSRST_START, .i_START_LATCH, .i_PARITY_CHECK_SET, .i_CYCLE_CHECK_SET,
   .i_MACHINE_ERROR, .i_LOAD_STATUS_OP, .i_INT_CYCLE, .i_INT_CYCLES_DONE, .o_MCK_INT_REQ, .o_INT_CYCLE_REQ,
   .o_INHIBIT_COMPUTE_CLOCK, .o_FORCE_END_EXECUTE, .o_MCK_END_EXECUTE, .o_MCK_INT_LATCH, .o_RESET_CPU_ERR,
   .o_HARDSTOP, .o_ANY_CPU_ERROR);

/* File: test/machine_check_response_tb_top.sv */
// testbench for the machine-check response block: scenarios, checks, verdict
// assumes the sequencer model and the bound checker are compiled before it
`timescale 1ns/100ps
module machine_check_response_tb_top;
   logic clk = 0, rst = 1, cc1 = 0, cc2 = 0, wc4 = 0, rc2 = 0, rc4 = 0, tmr = 0, cbtn = 0, sst = 0, l3 = 0;
   logic stl = 0, par = 0, cyc = 0, merr = 0, lso = 0, icy = 0, done = 0, pld = 0, rgn = 0, ext = 0;
   logic loop = 0, hit = 0, wr = 0, rd = 0, cp2, halted, ireq, icr, inh, fee, mee, il, rce, srr, hs, ae;
   logic [31:0] sw = 0, wd = 0, rdat;
   logic [1:0] sel = 0;
   logic [4:0] sqx = 0;
   logic [3:0] sqf = 0, adr = 0;
   int n_fail = 0, check_count = 0, cyc_n = 0;
   // ------------------------------------------------------------
   // block under test and far side
   // ------------------------------------------------------------
   machine_check_response uut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .i_CC1(cc1), .i_CC2(cc2), .i_WC4(wc4),
      .i_RC2(rc2), .i_RC4(rc4), .i_CP2(cp2), .i_STATUS_WORD_FIRST_HALF(sw), .i_CHECK_SEL(sel),
      .i_STORAGE_COMPARE_LOOP_SETTING(loop), .i_ADDR_COMPARE_MATCH(hit), .i_TIMER_PULSE(tmr),
      .i_CHECK_RESET_BUTTON(cbtn), .i_SYSRST_START(sst), .i_SYSRST_LATCH3(l3), .i_START_LATCH(stl),
      .i_PARITY_CHECK_SET(par), .i_CYCLE_CHECK_SET(cyc), .i_SEQ_FIXED(sqx), .i_SEQ_FLOAT(sqf),
      .i_MACHINE_ERROR(merr), .i_LOAD_STATUS_OP(lso), .i_INT_CYCLE(icy), .i_CLOCKS_HALTED(halted),
      .i_INT_CYCLES_DONE(done), .i_INITIAL_PROGRAM_LOAD(pld), .i_REGEN_STORAGE(rgn), .i_EXT_VALIDATE(ext),
      .i_ADDR(adr), .i_WDATA(wd), .i_WR(wr), .i_RD(rd), .o_RDATA(rdat), .o_MCK_INT_REQ(ireq),
      .o_INT_CYCLE_REQ(icr), .o_INHIBIT_COMPUTE_CLOCK(inh), .o_FORCE_END_EXECUTE(fee),
      .o_MCK_END_EXECUTE(mee), .o_MCK_INT_LATCH(il), .o_RESET_CPU_ERR(rce), .o_SYS_RESET_REQ(srr),
      .o_HARDSTOP(hs), .o_ANY_CPU_ERROR(ae));
   mck_sequencer_model #(.HALT_DLY(3)) u_seq (.i_clk(clk), .i_rst(rst), .i_req(ireq), .i_end_exec(mee),
      .o_halted(halted), .o_cp2(cp2));
   // clock, and a ceiling well above the fewer than two hundred cycles the scenarios need
   always #10 clk = ~clk;
   always @(posedge clk)
   begin
      cyc_n++;
      if (cyc_n == 3000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // register port: one-cycle strobes, read data only in the following cycle
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {wr, adr, wd} <= {1'b1, a, d};
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      {rd, adr} <= {1'b1, a};
      @(posedge clk);
      rd <= 0;
      #1 chk(rdat, e);
   endtask
   // clear checks, let any started interrupt finish, then clear the hardstop
   task automatic clean();
      @(posedge clk);
      {cbtn, sel, l3, loop, hit, sqx, sqf} <= 15'h4000;
      @(posedge clk);
      cbtn <= 0;
      repeat (6) @(posedge clk);
      done <= 1;
      @(posedge clk);
      {done, sst} <= 2'h1;
      @(posedge clk);
      sst <= 0;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_flow();
      int k;
      logic seen;
      seen = 0;
      @(posedge clk);
      {sw, par} <= {32'h0, 1'b1};
      @(posedge clk);
      par <= 0;
      #1 chk(ireq, 0);
      chk(ae, 1);
      @(posedge clk);
      {sel, sw} <= {2'h1, 32'h2000};
      #1 chk(ireq, 0);
      @(posedge clk);
      sel <= 0;
      #1 chk({icr, ireq}, 2'h3);
      for (k = 0; k < 30 && il !== 1'b1; k++)
      begin
         @(posedge clk);
         #1 seen = seen | mee;
      end
      chk({seen, il}, 2'h3);
      @(posedge clk);
      {wc4, lso} <= 2'h3;
      #1 chk(fee, 0);
      @(posedge clk);
      {lso, icy} <= 2'h1;
      #1 chk(fee, 0);
      @(posedge clk);
      icy <= 0;
      #1 chk(fee, 1);
      @(posedge clk);
      {wc4, rc2} <= 2'h1;
      #1 chk(rce, 1);
      @(posedge clk);
      {rc2, rc4} <= 2'h1;
      #1 chk(ae, 0);
      @(posedge clk);
      rc4 <= 0;
      rreg(4'h0, 32'h30);
      @(posedge clk);
      par <= 1;
      @(posedge clk);
      par <= 0;
      @(posedge clk);
      #1 chk({hs, il}, 2'h3);
      wreg(4'h4, 32'h3);
      @(posedge clk);
      done <= 1;
      #1 chk(ae, 0);
      @(posedge clk);
      {done, stl} <= 2'h1;
      #1 chk(il, 0);
      @(posedge clk);
      stl <= 0;
      #1 chk(hs, 0);
   endtask
   task automatic t_stop();
      @(posedge clk);
      {sel, cyc} <= 3'h5;
      @(posedge clk);
      cyc <= 0;
      #1 chk({ae, ireq}, 2'h2);
      @(posedge clk);
      #1 chk(hs, 1);
      clean();
      #1 chk(hs, 0);
   endtask
   task automatic t_merr();
      logic [5:0] tc [8];
      tc = '{6'h30, 6'h11, 6'h28, 6'h09, 6'h24, 6'h05, 6'h00, 6'h22};
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         {pld, rgn, ext, sel, merr} <= {tc[i][4:0], 1'b1};
         @(posedge clk);
         merr <= 0;
         #1 chk(hs, {31'h0, tc[i][5]});
         @(posedge clk);
         {sst, pld, rgn, ext, sel} <= 6'h20;
         @(posedge clk);
         sst <= 0;
      end
   endtask
   task automatic t_seq();
      @(posedge clk);
      {sqx, sqf, cc2} <= 10'h023;
      @(posedge clk);
      {sqx, cc2, cc1} <= 7'h0D;
      #1 chk(ae, 0);
      @(posedge clk);
      cc1 <= 0;
      #1 chk({ae, inh}, 2'h3);
      clean();
   endtask
   task automatic t_forced();
      @(posedge clk);
      {sw, sel, loop, l3, cc1} <= {32'h0, 5'h0F};
      @(posedge clk);
      cc1 <= 0;
      #1 chk({ae, ireq}, 2'h3);
      rreg(4'h0, 32'h0);
      @(posedge clk);
      hit <= 1;
      #1 chk(srr, 1);
      // with loop enable cleared the compare hit must not restart
      wreg(4'h4, 32'h0);
      #1 chk(srr, 0);
      wreg(4'h4, 32'h2);
      clean();
      @(posedge clk);
      {sel, tmr} <= 3'h7;
      #1 chk(srr, 1);
      @(posedge clk);
      {tmr, l3, cc2} <= 3'h3;
      @(posedge clk);
      cc2 <= 0;
      #1 chk(ae, 1);
      clean();
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 0;
      rreg(4'h0, 32'h0);
      rreg(4'h4, 32'h2);
      rreg(4'h8, 32'h0);
      t_flow();
      t_stop();
      t_merr();
      t_seq();
      t_forced();
      report_and_stop();
   end
endmodule
